// >>> inc/cab_cfg.svh
// Constants for the add and branch execution block
`ifndef CAB_CFG_SVH
`define CAB_CFG_SVH

// ****************************************************************
// Status bit positions
// ****************************************************************
`define CAB_ST_C          0
`define CAB_ST_DC         1
`define CAB_ST_Z          2
`define CAB_ST_OV         3
`define CAB_ST_N          4

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define CAB_OPC_ADDC      6'h08
`define CAB_OPC_ANDF      6'h05
`define CAB_OPC_ANDL      8'h0B
`define CAB_OPC_BCLR      4'h9
`define CAB_OPC_BRC       8'hE2
`define CAB_OPC_BRNC      8'hE3
`define CAB_OPC_BRN       8'hE6
`define CAB_OPC_BRNN      8'hE7

// ****************************************************************
// Addressing
// ****************************************************************
`define CAB_IDX_LIMIT     8'h5F
`define CAB_LOW_BANK      4'h0
`define CAB_SFR_BANK      4'hF
`define CAB_BR_STEP       21'h000002

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CAB_REG_CTRL      8'h00
`define CAB_REG_ACC       8'h04
`define CAB_REG_STATUS    8'h08
`define CAB_REG_BANK      8'h0C
`define CAB_REG_IDXBASE   8'h10
`define CAB_REG_LASTPC    8'h14
`define CAB_REG_RETIRED   8'h18

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define CAB_CTRL_EXT      0
`define CAB_CTRL_BADOP    8
`define CAB_RST_ACC       8'h00
`define CAB_RST_STATUS    5'h00
`define CAB_RST_BANK      4'h0
`define CAB_RST_IDX       12'h000
`define CAB_RST_PC        21'h000000
`define CAB_RST_RETIRED   16'h0000

// ****************************************************************
// Bus responses
// ****************************************************************
`define CAB_RESP_OKAY     2'h0
`define CAB_RESP_SLVERR   2'h2

`endif

// >>> inc/cab_pkg.sv
// Types shared by the add and branch execution block
package cab_pkg;

  typedef enum logic [1:0] {
    ST_READ = 2'h0,
    ST_EXEC = 2'h1,
    ST_NOPA = 2'h3,
    ST_NOPB = 2'h2
  } cab_state_e;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_ADDC   = 3'h1,
    OP_ANDL   = 3'h2,
    OP_ANDF   = 3'h3,
    OP_BCLR   = 3'h4,
    OP_BRANCH = 3'h5
  } cab_op_e;

  typedef logic [11:0] cab_daddr_t;
  typedef logic [20:0] cab_pc_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    cab_pc_t     addr;
  } cab_fetch_s;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic [2:0]  awprot;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic [2:0]  arprot;
    logic        rready;
  } cab_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cab_axi_rsp_s;

endpackage

// >>> sim/cab_exec_sva.sv
// Port-level checks for the add and branch execution block
`timescale 1ns/10ps
module cab_exec_chk (
  input logic                  clock,
  input logic                  resetn,
  input logic                  ce,
  input cab_pkg::cab_fetch_s   fetch,
  input logic                  fetchReady,
  input logic                  pcLoad,
  input cab_pkg::cab_pc_t      pcTarget,
  input cab_pkg::cab_axi_req_s axiReq,
  input cab_pkg::cab_axi_rsp_s axiRsp
);
  import cab_pkg::*;
  logic       take;
  logic       isBr;
  cab_pc_t    tAddr;
  logic [7:0] tOff;

  assign take = ce && fetchReady && fetch.valid;
  assign isBr = (fetch.word[15:11] == 5'h1C) && fetch.word[9];

  // ****
  // Branch base and offset at each take
  // ****
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tAddr <= '0;
      tOff  <= '0;
    end else if (take) begin
      tAddr <= fetch.addr;
      tOff  <= fetch.word[7:0];
    end
  end

  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn || !ce);

  busy_after_take_a: assert property (take |=> !fetchReady)
    else $error("fetch ready after take");
  one_cycle_op_a: assert property (
    take && !isBr |=> !fetchReady ##1 fetchReady)
    else $error("plain op length wrong");
  no_load_op_a: assert property (take && !isBr |=> !pcLoad [*3])
    else $error("pc load on plain op");
  branch_len_a: assert property (
    take && isBr |=> !fetchReady ##1 (pcLoad || fetchReady))
    else $error("branch length wrong");
  load_pulse_a: assert property (
    pcLoad |-> !fetchReady ##1 (!pcLoad && !fetchReady) ##1 fetchReady)
    else $error("taken branch slot wrong");
  target_calc_a: assert property (
    pcLoad |-> pcTarget == tAddr + 21'h000002 + {{12{tOff[7]}}, tOff, 1'h0})
    else $error("branch target wrong");
  target_hold_a: assert property ($changed(pcTarget) |-> pcLoad)
    else $error("target moved without load");
  read_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  read_busy_a: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read address open while answering");
  write_answer_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |-> ##[1:2] axiRsp.bvalid)
    else $error("write answer late");

  // ****
  // Covers
  // ****
  cover property (take && isBr);
  cover property (pcLoad);
  cover property (axiRsp.bvalid && axiReq.bready);
  cover property (axiRsp.rvalid && axiRsp.rresp == 2'h2);
endmodule // cab_exec_chk

// >>> sim/tb_cab_exec.sv
// Self-checking bench for the add and branch execution block
`timescale 1ns/10ps
`include "cab_cfg.svh"
module tb_cab_exec;
  import cab_pkg::*;
  logic         clock = 1'h0;
  logic         resetn = 1'h0;
  logic         ce = 1'h1;
  cab_fetch_s   fetch = '0;
  cab_axi_req_s axiReq = '0;
  logic         fetchReady;
  logic         pcLoad;
  cab_pc_t      pcTarget;
  cab_axi_rsp_s axiRsp;
  cab_pc_t      tgt;
  logic [31:0]  rd;
  logic [1:0]   rsp;
  logic         seen;
  logic         fl;
  logic         tk;
  logic [4:0]   st;
  int           cyc;
  int           num_errors = 0;
  int           checks = 0;
  // Word, acc in, status in, acc out, status out
  logic [47:0]  vec [13] = '{48'h1620_0000_0004, 48'h2220_0200_0200, 48'h2020_4D01_5002,
    48'h2020_7F00_811A, 48'h2020_FE00_0007, 48'h0B5F_A31B_030B, 48'h1420_FF1F_020B,
    48'h9220_001F_001F, 48'h2020_0000_0004, 48'h1720_0000_0004, 48'h2320_1000_1000,
    48'h2020_0000_0004, 48'h2120_0000_1000};

  always #20 clock = ~clock;

  cab_exec u_dut (
    .clock      (clock),
    .resetn     (resetn),
    .ce         (ce),
    .fetch      (fetch),
    .fetchReady (fetchReady),
    .pcLoad     (pcLoad),
    .pcTarget   (pcTarget),
    .axiReq     (axiReq),
    .axiRsp     (axiRsp)
  );

  // ****
  // Bus and fetch tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    axiReq.awaddr  <= a;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hF;
    axiReq.awvalid <= 1'h1;
    axiReq.wvalid  <= 1'h1;
    axiReq.bready  <= 1'h1;
    do begin
      @(posedge clock);
      if (axiRsp.awready) axiReq.awvalid <= 1'h0;
      if (axiRsp.wready) axiReq.wvalid <= 1'h0;
    end while (axiRsp.bvalid !== 1'h1);
    rsp = axiRsp.bresp;
    axiReq.bready <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    axiReq.araddr  <= a;
    axiReq.arvalid <= 1'h1;
    axiReq.rready  <= 1'h1;
    do begin
      @(posedge clock);
      if (axiRsp.arready) axiReq.arvalid <= 1'h0;
    end while (axiRsp.rvalid !== 1'h1);
    rd  = axiRsp.rdata;
    rsp = axiRsp.rresp;
    axiReq.rready <= 1'h0;
    chk(rd, exp, "read data");
    chk(32'(rsp), 32'(er), "read resp");
  endtask

  // Offer one word, then count clocks until the next take is possible
  task automatic run(input logic [15:0] w, input cab_pc_t a);
    @(posedge clock);
    fetch <= '{1'h1, w, a};
    do @(posedge clock); while (fetchReady !== 1'h1);
    fetch.valid <= 1'h0;
    seen = 1'h0;
    cyc  = 0;
    do begin
      @(posedge clock);
      if (pcLoad === 1'h1) begin
        seen = 1'h1;
        tgt  = pcTarget;
      end
      cyc++;
    end while (fetchReady !== 1'h1 && cyc < 8);
  endtask

  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'h1;
    for (int i = 0; i < 7; i++) rdchk(8'(4 * i), 32'h0, `CAB_RESP_OKAY);
    rdchk(8'h1C, 32'h0, `CAB_RESP_SLVERR);
    wr(8'h40, 32'hFFFFFFFF);
    chk(32'(rsp), 32'(`CAB_RESP_SLVERR), "write resp");
    wr(`CAB_REG_BANK, 32'h5);
    foreach (vec[i]) begin
      wr(`CAB_REG_ACC, {24'h0, vec[i][31:24]});
      wr(`CAB_REG_STATUS, {24'h0, vec[i][23:16]});
      run(vec[i][47:32], 21'h0);
      rdchk(`CAB_REG_ACC, {24'h0, vec[i][15:8]}, `CAB_RESP_OKAY);
      rdchk(`CAB_REG_STATUS, {24'h0, vec[i][7:0]}, `CAB_RESP_OKAY);
    end
    wr(`CAB_REG_CTRL, 32'h1);
    wr(`CAB_REG_IDXBASE, 32'h500);
    wr(`CAB_REG_ACC, 32'h0);
    run(16'h2020, 21'h0);
    rdchk(`CAB_REG_ACC, 32'h10, `CAB_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      fl = i[0];
      tk = fl ^ i[1];
      st = i[2] ? {fl, 3'h0, ~fl} : {~fl, 3'h0, fl};
      wr(`CAB_REG_STATUS, {27'h0, st});
      run({5'h1C, i[2], 1'h1, i[1], fl ? 8'h80 : 8'h7F}, 21'h000100);
      chk(32'(seen), 32'(tk), "taken");
      chk(cyc, tk ? 32'h4 : 32'h2, "cycles");
      if (tk) chk(32'(tgt), fl ? 32'h2 : 32'h200, "target");
      rdchk(`CAB_REG_STATUS, {27'h0, st}, `CAB_RESP_OKAY);
    end
    rdchk(`CAB_REG_LASTPC, 32'h200, `CAB_RESP_OKAY);
    // Frozen clock enable: an offered literal AND must not execute
    @(posedge clock);
    ce    <= 1'h0;
    fetch <= '{1'h1, 16'h0B00, 21'h0};
    repeat (3) @(posedge clock);
    ce          <= 1'h1;
    fetch.valid <= 1'h0;
    rdchk(`CAB_REG_ACC, 32'h10, `CAB_RESP_OKAY);
    // Unsupported opcode sets the sticky flag, write one clears it
    run(16'h0000, 21'h0);
    rdchk(`CAB_REG_CTRL, 32'h101, `CAB_RESP_OKAY);
    wr(`CAB_REG_CTRL, 32'h101);
    chk(32'(rsp), 32'(`CAB_RESP_OKAY), "write resp");
    rdchk(`CAB_REG_CTRL, 32'h1, `CAB_RESP_OKAY);
    rdchk(`CAB_REG_RETIRED, 32'h17, `CAB_RESP_OKAY);
    summarize();
  end

  initial begin
    #100us;
    num_errors++;
    summarize();
  end
endmodule // tb_cab_exec

bind cab_exec cab_exec_chk u_chk (
  .clock      (clock),
  .resetn     (resetn),
  .ce         (ce),
  .fetch      (fetch),
  .fetchReady (fetchReady),
  .pcLoad     (pcLoad),
  .pcTarget   (pcTarget),
  .axiReq     (axiReq),
  .axiRsp     (axiRsp)
);

// >>> verilog/cab_data_mem.sv
// Data memory with registered read port
`timescale 1ns/10ps
module cab_data_mem (
  input  logic              clock,
  input  logic              resetn,
  input  logic              ce,
  input  logic              rdEn,
  input  logic              wrEn,
  input  cab_pkg::cab_daddr_t addr,
  input  logic [7:0]        wdata,
  output logic [7:0]        rdata
);
  import cab_pkg::*;

  logic [7:0] mem [0:4095];
  logic [7:0] rdata_q;

  always_ff @(posedge clock) begin
    if (ce && wrEn) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (ce && rdEn) begin
      rdata_q <= mem[addr];
    end
  end

  assign rdata = rdata_q;
endmodule // cab_data_mem

// >>> verilog/cab_exec.sv
// Execution of add-with-carry, AND, bit clear and carry/sign branches
`timescale 1ns/10ps
`include "cab_cfg.svh"
module cab_exec (
  input  logic                  clock,
  input  logic                  resetn,
  input  logic                  ce,
  input  cab_pkg::cab_fetch_s   fetch,
  output logic                  fetchReady,
  output logic                  pcLoad,
  output cab_pkg::cab_pc_t      pcTarget,
  input  cab_pkg::cab_axi_req_s axiReq,
  output cab_pkg::cab_axi_rsp_s axiRsp
);
  import cab_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic cab_op_e decodeOp(input logic [15:0] w);
    cab_op_e op;
    op = OP_NONE;
    if (w[15:10] == `CAB_OPC_ADDC) begin
      op = OP_ADDC;
    end else if (w[15:8] == `CAB_OPC_ANDL) begin
      op = OP_ANDL;
    end else if (w[15:10] == `CAB_OPC_ANDF) begin
      op = OP_ANDF;
    end else if (w[15:12] == `CAB_OPC_BCLR) begin
      op = OP_BCLR;
    end else if (w[15:8] == `CAB_OPC_BRC || w[15:8] == `CAB_OPC_BRNC ||
                 w[15:8] == `CAB_OPC_BRN || w[15:8] == `CAB_OPC_BRNN) begin
      op = OP_BRANCH;
    end
    return op;
  endfunction

  function automatic logic isFileOp(input cab_op_e op);
    return (op == OP_ADDC) || (op == OP_ANDF) || (op == OP_BCLR);
  endfunction

  function automatic logic regMapped(input logic [7:0] a);
    return (a == `CAB_REG_CTRL) || (a == `CAB_REG_ACC) || (a == `CAB_REG_STATUS) ||
           (a == `CAB_REG_BANK) || (a == `CAB_REG_IDXBASE) ||
           (a == `CAB_REG_LASTPC) || (a == `CAB_REG_RETIRED);
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cab_state_e  state_q;
  cab_state_e  state_d;
  logic [15:0] instr_q;
  cab_pc_t     instrAddr_q;
  cab_daddr_t  fileAddr_q;
  logic        fetchReady_q;
  logic        pcLoad_q;
  cab_pc_t     pcTarget_q;
  logic [7:0]  acc_q;
  logic [4:0]  status_q;
  logic [3:0]  bank_q;
  logic [11:0] idxBase_q;
  logic        extEn_q;
  logic        badOp_q;
  logic [15:0] retired_q;

  logic        take;
  logic        exec;
  cab_op_e     fetchOp;
  cab_op_e     op;
  cab_daddr_t  fetchAddr;
  cab_daddr_t  memAddr;
  logic        memRd;
  logic        memWr;
  logic [7:0]  memRdata;
  logic [7:0]  memWdata;
  logic [8:0]  sum9;
  logic [4:0]  low5;
  logic [7:0]  andRes;
  logic [7:0]  clrRes;
  logic [7:0]  result;
  logic        destFile;
  logic        accWr;
  logic        flagWr;
  logic [4:0]  newStatus;
  logic        brCond;
  logic        taken;
  cab_pc_t     brTarget;

  // Bus slave state
  logic        awHeld_q;
  logic [7:0]  awAddr_q;
  logic        wHeld_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        awRdy_q;
  logic        wRdy_q;
  logic        bValid_q;
  logic [1:0]  bResp_q;
  logic        arRdy_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;
  logic        swWr;
  logic        swHit;
  logic [31:0] rdMux;

  // ****************************************************************
  // Fetch and file addressing
  // ****************************************************************
  assign take    = ce && (state_q == ST_READ) && fetch.valid;
  assign exec    = ce && (state_q == ST_EXEC);
  assign fetchOp = decodeOp(fetch.word);
  assign op      = decodeOp(instr_q);

  always_comb begin
    if (fetch.word[8]) begin
      fetchAddr = {bank_q, fetch.word[7:0]};
    end else if (extEn_q && fetch.word[7:0] <= `CAB_IDX_LIMIT) begin
      fetchAddr = cab_daddr_t'(idxBase_q + {4'h0, fetch.word[7:0]});
    end else if (fetch.word[7:0] <= `CAB_IDX_LIMIT) begin
      fetchAddr = {`CAB_LOW_BANK, fetch.word[7:0]};
    end else begin
      fetchAddr = {`CAB_SFR_BANK, fetch.word[7:0]};
    end
  end

  assign memRd   = take && isFileOp(fetchOp);
  assign memAddr = (state_q == ST_EXEC) ? fileAddr_q : fetchAddr;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      instr_q     <= 16'h0000;
      instrAddr_q <= `CAB_RST_PC;
      fileAddr_q  <= 12'h000;
    end else if (take) begin
      instr_q     <= fetch.word;
      instrAddr_q <= fetch.addr;
      fileAddr_q  <= fetchAddr;
    end
  end

  cab_data_mem u_mem (
    .clock  (clock),
    .resetn (resetn),
    .ce     (ce),
    .rdEn   (memRd),
    .wrEn   (memWr),
    .addr   (memAddr),
    .wdata  (memWdata),
    .rdata  (memRdata)
  );

  // ****************************************************************
  // Arithmetic and logic
  // ****************************************************************
  assign sum9     = {1'b0, acc_q} + {1'b0, memRdata} + {8'h00, status_q[`CAB_ST_C]};
  assign low5     = {1'b0, acc_q[3:0]} + {1'b0, memRdata[3:0]} +
                    {4'h0, status_q[`CAB_ST_C]};
  assign andRes   = acc_q & ((op == OP_ANDL) ? instr_q[7:0] : memRdata);
  assign clrRes   = memRdata & ~(8'h01 << instr_q[11:9]);
  assign destFile = instr_q[9];

  always_comb begin
    result    = andRes;
    newStatus = status_q;
    flagWr    = 1'b0;
    accWr     = 1'b0;
    memWr     = 1'b0;
    case (op)
      OP_ADDC: begin
        result                 = sum9[7:0];
        newStatus[`CAB_ST_C]   = sum9[8];
        newStatus[`CAB_ST_DC]  = low5[4];
        newStatus[`CAB_ST_OV]  = (acc_q[7] == memRdata[7]) && (sum9[7] != acc_q[7]);
        newStatus[`CAB_ST_N]   = sum9[7];
        newStatus[`CAB_ST_Z]   = (sum9[7:0] == 8'h00);
        flagWr                 = exec;
        accWr                  = exec && !destFile;
        memWr                  = exec && destFile;
      end
      OP_ANDL: begin
        newStatus[`CAB_ST_N]   = andRes[7];
        newStatus[`CAB_ST_Z]   = (andRes == 8'h00);
        flagWr                 = exec;
        accWr                  = exec;
      end
      OP_ANDF: begin
        newStatus[`CAB_ST_N]   = andRes[7];
        newStatus[`CAB_ST_Z]   = (andRes == 8'h00);
        flagWr                 = exec;
        accWr                  = exec && !destFile;
        memWr                  = exec && destFile;
      end
      OP_BCLR: begin
        result                 = clrRes;
        memWr                  = exec;
      end
      default: begin
        result                 = andRes;
      end
    endcase
  end

  assign memWdata = result;

  // ****************************************************************
  // Branch evaluation
  // ****************************************************************
  // Bit 10 picks sign or carry, bit 8 inverts the sense
  assign brCond   = (instr_q[10] ? status_q[`CAB_ST_N] : status_q[`CAB_ST_C]) ^ instr_q[8];
  assign taken    = exec && (op == OP_BRANCH) && brCond;
  assign brTarget = cab_pc_t'(instrAddr_q + `CAB_BR_STEP +
                              {{12{instr_q[7]}}, instr_q[7:0], 1'b0});

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    case (state_q)
      ST_READ: state_d = take ? ST_EXEC : ST_READ;
      ST_EXEC: state_d = taken ? ST_NOPA : ST_READ;
      ST_NOPA: state_d = ST_NOPB;
      ST_NOPB: state_d = ST_READ;
      default: state_d = ST_READ;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q      <= ST_READ;
      fetchReady_q <= 1'b1;
    end else if (ce) begin
      state_q      <= state_d;
      fetchReady_q <= (state_d == ST_READ);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pcLoad_q   <= 1'b0;
      pcTarget_q <= `CAB_RST_PC;
    end else if (ce) begin
      pcLoad_q <= taken;
      if (taken) begin
        pcTarget_q <= brTarget;
      end
    end
  end

  // ****************************************************************
  // Core registers
  // ****************************************************************
  assign swWr  = ce && awHeld_q && wHeld_q && !bValid_q;
  assign swHit = regMapped(awAddr_q);

  // Core updates win over a software write in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_q <= `CAB_RST_ACC;
    end else if (accWr) begin
      acc_q <= result;
    end else if (swWr && awAddr_q == `CAB_REG_ACC) begin
      acc_q <= 8'(mergeStrb({24'h000000, acc_q}, wData_q, wStrb_q));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_q <= `CAB_RST_STATUS;
    end else if (flagWr) begin
      status_q <= newStatus;
    end else if (swWr && awAddr_q == `CAB_REG_STATUS) begin
      status_q <= 5'(mergeStrb({27'h0000000, status_q}, wData_q, wStrb_q));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bank_q    <= `CAB_RST_BANK;
      idxBase_q <= `CAB_RST_IDX;
      extEn_q   <= 1'b0;
    end else if (swWr) begin
      if (awAddr_q == `CAB_REG_BANK) begin
        bank_q <= 4'(mergeStrb({28'h0000000, bank_q}, wData_q, wStrb_q));
      end
      if (awAddr_q == `CAB_REG_IDXBASE) begin
        idxBase_q <= 12'(mergeStrb({20'h00000, idxBase_q}, wData_q, wStrb_q));
      end
      if (awAddr_q == `CAB_REG_CTRL && wStrb_q[0]) begin
        extEn_q <= wData_q[`CAB_CTRL_EXT];
      end
    end
  end

  // Unsupported opcode is sticky; a new event beats a clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      badOp_q <= 1'b0;
    end else if (exec && op == OP_NONE) begin
      badOp_q <= 1'b1;
    end else if (swWr && awAddr_q == `CAB_REG_CTRL && wStrb_q[1] &&
                 wData_q[`CAB_CTRL_BADOP]) begin
      badOp_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      retired_q <= `CAB_RST_RETIRED;
    end else if (exec) begin
      retired_q <= retired_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Bus write channels
  // ****************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      awRdy_q  <= 1'b1;
    end else if (ce) begin
      if (axiReq.awvalid && awRdy_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {axiReq.awaddr[7:2], 2'b00};
        awRdy_q  <= 1'b0;
      end else if (swWr) begin
        awHeld_q <= 1'b0;
        awRdy_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      wRdy_q  <= 1'b1;
    end else if (ce) begin
      if (axiReq.wvalid && wRdy_q) begin
        wHeld_q <= 1'b1;
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
        wRdy_q  <= 1'b0;
      end else if (swWr) begin
        wHeld_q <= 1'b0;
        wRdy_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bValid_q <= 1'b0;
      bResp_q  <= `CAB_RESP_OKAY;
    end else if (ce) begin
      if (swWr) begin
        bValid_q <= 1'b1;
        bResp_q  <= swHit ? `CAB_RESP_OKAY : `CAB_RESP_SLVERR;
      end else if (bValid_q && axiReq.bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Bus read channel
  // ****************************************************************
  always_comb begin
    case ({axiReq.araddr[7:2], 2'b00})
      `CAB_REG_CTRL:    rdMux = {23'h000000, badOp_q, 7'h00, extEn_q};
      `CAB_REG_ACC:     rdMux = {24'h000000, acc_q};
      `CAB_REG_STATUS:  rdMux = {27'h0000000, status_q};
      `CAB_REG_BANK:    rdMux = {28'h0000000, bank_q};
      `CAB_REG_IDXBASE: rdMux = {20'h00000, idxBase_q};
      `CAB_REG_LASTPC:  rdMux = {11'h000, pcTarget_q};
      `CAB_REG_RETIRED: rdMux = {16'h0000, retired_q};
      default:          rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arRdy_q  <= 1'b1;
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= `CAB_RESP_OKAY;
    end else if (ce) begin
      if (axiReq.arvalid && arRdy_q) begin
        arRdy_q  <= 1'b0;
        rValid_q <= 1'b1;
        rData_q  <= rdMux;
        rResp_q  <= regMapped({axiReq.araddr[7:2], 2'b00}) ? `CAB_RESP_OKAY
                                                            : `CAB_RESP_SLVERR;
      end else if (rValid_q && axiReq.rready) begin
        rValid_q <= 1'b0;
        arRdy_q  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign fetchReady     = fetchReady_q;
  assign pcLoad         = pcLoad_q;
  assign pcTarget       = pcTarget_q;
  assign axiRsp.awready = awRdy_q;
  assign axiRsp.wready  = wRdy_q;
  assign axiRsp.bvalid  = bValid_q;
  assign axiRsp.bresp   = bResp_q;
  assign axiRsp.arready = arRdy_q;
  assign axiRsp.rvalid  = rValid_q;
  assign axiRsp.rdata   = rData_q;
  assign axiRsp.rresp   = rResp_q;
endmodule // cab_exec
